/* File: dv/acc_core_sva.sv */
// Port assertions for the serial command and calibration block
`timescale 1ns/1ps
module acc_core_sva
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic      core_clk,
  input wire logic      rst,
  // Inputs of the block
  input wire acc_pins_s pins,
  input wire acc_conv_s conv,
  input wire logic      sinc_mode,
  // Outputs of the block
  input wire logic      sdout,
  input wire logic      sdout_oe,
  input wire logic      data_ready_n,
  input wire logic      conv_restart,
  input wire logic      standby,
  input wire logic      offset_en,
  input wire logic      gain_en
);
  // Single domain, so one clock and one reset serve all checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Four samples cover the two sync stages plus the output register
  oe_release_a: assert property (pins.cs_n [*4] |-> !sdout_oe)
    else $error("output enabled while deselected");
  standby_exit_a: assert property (pins.cs_n [*4] |-> !standby)
    else $error("standby kept while deselected");
  // Ready only falls on a fresh result, with its top bit on the pin
  ready_load_a: assert property (
    $fell(data_ready_n) |-> $past(conv.valid))
    else $error("ready fell without a result");
  msb_first_a: assert property (
    $fell(data_ready_n) |-> sdout == $past(conv.data[31]))
    else $error("first bit is not the top bit");
  restart_pulse_a: assert property (conv_restart |=> !conv_restart)
    else $error("restart longer than one cycle");
  // A restart throws away the readings that follow it
  write_settle_a: assert property (
    conv_restart |=> data_ready_n [*8])
    else $error("ready low right after restart");
  sinc_bypass_a: assert property (
    sinc_mode [*2] |-> !offset_en && !gain_en)
    else $error("correction on in sinc mode");
  // Averaging is the only reason for the enable to drop here
  cal_hold_a: assert property (
    !sinc_mode [*2] ##0 !gain_en |-> data_ready_n)
    else $error("ready low during calibration");

  // Main scenarios reached
  cover property ($fell(data_ready_n));
  cover property (conv_restart);
  cover property ($rose(standby));
  cover property (!sinc_mode && !offset_en);
endmodule

bind acc_core acc_core_sva u_sva (
  .core_clk     (core_clk),
  .rst          (rst),
  .pins         (pins),
  .conv         (conv),
  .sinc_mode    (sinc_mode),
  .sdout        (sdout),
  .sdout_oe     (sdout_oe),
  .data_ready_n (data_ready_n),
  .conv_restart (conv_restart),
  .standby      (standby),
  .offset_en    (offset_en),
  .gain_en      (gain_en)
);

/* File: dv/acc_host_model.sv */
// Host serial controller model that clocks command bytes
`timescale 1ns/1ps
module acc_host_model
  import acc_pkg::*;
(
  // Clock
  input  wire logic core_clk,
  // Link toward the device
  output acc_pins_s pins,
  input  wire logic sdout,
  input  wire logic sdout_oe
);
  // Half period of the 80 ns link clock, in core cycles
  localparam int HALF = 4;
  // Idle after a byte; with HALF gives 28 cycles rise to rise
  localparam int GAP = 20;

  // Link clock stands low and device deselected outside frames
  initial pins = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};

  // Waits n core cycles and lands just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Select stays put across a whole command sequence
  task automatic sel(input logic v);
    tick(GAP);
    pins.cs_n = v;
    tick(GAP);
  endtask

  // One byte top bit first; reads at the end of the high phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      pins.din = tx[i];
      tick(HALF);
      pins.sclk = 1'b1;
      tick(HALF);
      // A released pin has no pull; show the inverse so stale bits fail
      rx[i] = sdout_oe ? sdout : ~sdout;
      pins.sclk = 1'b0;
    end
    tick(GAP);
  endtask
endmodule

/* File: dv/test_acc_core.sv */
// Self-checking bench for the serial command and calibration block
`timescale 1ns/1ps
module test_acc_core
  import acc_pkg::*;
();
  // Data period of the stand-in filter; fits a five byte read
  localparam int PER = 450;
  typedef struct packed {logic [7:0] op; logic sb; logic rs;} acc_row_s;
  // Single byte commands: opcode, standby after, restart seen
  localparam acc_row_s ROWS [8] = '{
    '{8'h02, 1'b1, 1'b0}, '{8'h03, 1'b1, 1'b0}, '{8'h00, 1'b0, 1'b0},
    '{8'h04, 1'b0, 1'b1}, '{8'h05, 1'b0, 1'b1}, '{8'h06, 1'b0, 1'b1},
    '{8'h07, 1'b0, 1'b1}, '{8'hf3, 1'b0, 1'b0}};
  logic        core_clk;
  logic        rst;
  logic        sinc_mode;
  acc_conv_s   conv = '0;
  logic [31:0] cdat = 32'h9a5c3e71;  // Result the filter hands over
  wire acc_pins_s pins;
  wire logic   sdout, sdout_oe, data_ready_n, conv_restart, standby;
  wire logic   offset_en, gain_en;
  wire logic [23:0] offset_word, gain_word;
  int          num_errors = 0;
  int          n_tests = 0;
  int          ph = 0, vcnt = 0, vr = 0, ve = 0, rcnt = 0;
  int          v1 = 0, v2 = 0;   // Period count one and two edges back
  logic        gprev = 1'b0;

  acc_core DUT (
    .core_clk     (core_clk),
    .rst          (rst),
    .pins         (pins),
    .conv         (conv),
    .sinc_mode    (sinc_mode),
    .sdout        (sdout),
    .sdout_oe     (sdout_oe),
    .data_ready_n (data_ready_n),
    .conv_restart (conv_restart),
    .standby      (standby),
    .offset_en    (offset_en),
    .gain_en      (gain_en),
    .offset_word  (offset_word),
    .gain_word    (gain_word)
  );
  acc_host_model HOST (
    .core_clk     (core_clk),
    .pins         (pins),
    .sdout        (sdout),
    .sdout_oe     (sdout_oe)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Filter stand-in; data is inverted between pulses so stale is seen
  always @(posedge core_clk) begin
    #1;
    ph = (ph == PER - 1) ? 0 : ph + 1;
    conv.valid = (ph == 0);
    conv.data = (ph == 0) ? cdat : ~cdat;
    if (ph == 0) vcnt++;
  end

  // Notes the period count at each restart and averaging start; the
  // counts are taken from before the edge at which the design changed
  // state, so a result in the very next cycle is not missed
  always @(posedge core_clk) begin
    gprev <= gain_en;
    v1 <= vcnt;
    v2 <= v1;
    if (conv_restart === 1'b1) begin
      rcnt <= rcnt + 1;
      vr <= v1;
    end
    if (gprev === 1'b1 && gain_en === 1'b0) ve <= v2;
  end

  // A bounded wait that ran out counts a mismatch and ends the run
  task automatic limit(input int n, input int lim);
    if (n >= lim) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, n, lim);
      test_done();
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [7:0] q [$]);
    logic [7:0] rx;
    foreach (q[i]) HOST.xfer(q[i], rx);
  endtask

  task automatic test_done();
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    logic [7:0]  rx;
    logic [39:0] q;
    logic [7:0]  ex [7];
    int          n, r0;
    ex = '{8'h03, 8'h00, 8'h00, 8'h40, 8'hff, 8'hff, 8'h7f};
    rst = 1'b1;
    sinc_mode = 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
    chk({data_ready_n, offset_word}, 32'h1000000);
    chk(gain_word, 32'h400000);
    rst = 1'b0;
    // Stop, resync, continuous: ready after the settle periods
    HOST.sel(1'b0);
    send('{8'h11, 8'h04, 8'h10});
    for (n = 0; n < 70 * PER && data_ready_n !== 1'b0; n++) HOST.tick(1);
    limit(n, 70 * PER);
    chk(vcnt - vr, 65);
    for (int i = 0; i < 5; i++) begin
      HOST.xfer(8'h00, rx);
      q = {q[31:0], rx};
    end
    chk(q[39:8], cdat);
    chk(q[7:0], 0);
    // Offset then gain calibration on a steady half-scale input
    cdat = 32'h40000000;
    send('{8'h11, 8'h60, 8'h10});
    for (n = 0; n < 20 * PER && offset_word !== 24'h400000; n++) HOST.tick(1);
    limit(n, 20 * PER);
    chk(vcnt - ve, 16);
    chk(offset_word, 32'h400000);
    send('{8'h11, 8'h61, 8'h10});
    for (n = 0; n < 20 * PER && gain_word !== 24'h7fffff; n++) HOST.tick(1);
    limit(n, 20 * PER);
    chk(vcnt - ve, 16);
    chk(gain_word, 32'h7fffff);
    // Read seven registers from address 4 in stop mode
    send('{8'h11, 8'h24, 8'h06});
    for (int i = 0; i < 7; i++) begin
      HOST.xfer(8'h00, rx);
      chk(rx, ex[i]);
    end
    // Single read by command while stopped
    send('{8'h12});
    for (n = 0; n < 2 * PER && data_ready_n !== 1'b0; n++) HOST.tick(1);
    limit(n, 2 * PER);
    for (int i = 0; i < 4; i++) begin
      HOST.xfer(8'h00, rx);
      q = {q[31:0], rx};
    end
    chk(q[31:0], cdat);
    // Write three gain bytes; conversion restarts
    r0 = rcnt;
    send('{8'h48, 8'h02, 8'h00, 8'h00, 8'h20});
    chk(gain_word, 32'h200000);
    chk(rcnt != r0, 1);
    sinc_mode = 1'b1;
    HOST.tick(3);
    chk({offset_en, gain_en}, 0);
    sinc_mode = 1'b0;
    HOST.tick(3);
    chk({offset_en, gain_en}, 3);
    HOST.sel(1'b1);
    // One frame per control command
    foreach (ROWS[i]) begin
      r0 = rcnt;
      HOST.sel(1'b0);
      HOST.xfer(ROWS[i].op, rx);
      chk({standby, rcnt != r0}, {ROWS[i].sb, ROWS[i].rs});
      HOST.sel(1'b1);
    end
    chk(gain_word, 32'h400000);
    // Wake in frame, then leaving standby by deselect
    HOST.sel(1'b0);
    send('{8'h03, 8'h01});
    chk(standby, 0);
    send('{8'h02});
    HOST.sel(1'b1);
    chk(standby, 0);
    // Registers hold in standby; a hardware reset in a frame restores the defaults
    HOST.sel(1'b0);
    send('{8'h02, 8'h48, 8'h00, 8'h11});
    chk({standby, gain_word}, {1'b1, 24'h400011});
    rst = 1'b1;
    HOST.tick(2);
    chk({standby, gain_word}, {1'b0, 24'h400000});
    rst = 1'b0;
    HOST.tick(5);
    chk({sdout_oe, data_ready_n}, 2'h3);
    test_done();
  end
endmodule

/* File: hdl/acc_core.sv */
// Serial command decoder, register file and calibration sequencer
`timescale 1ns/1ps

module acc_core
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Serial pins from the host
  input  wire acc_pins_s   pins,
  // Conversion results from the filter
  input  wire acc_conv_s   conv,
  input  wire logic        sinc_mode,
  // Serial output pin
  output logic             sdout,
  output logic             sdout_oe,
  output logic             data_ready_n,
  // Controls toward the converter
  output logic             conv_restart,
  output logic             standby,
  output logic             offset_en,
  output logic             gain_en,
  output logic [23:0]      offset_word,
  output logic [23:0]      gain_word
);

  // Pin synchronisers; first stages feed only second stages
  logic                     cs_m_q, cs_s_q;
  logic                     sclk_m_q, sclk_s_q, sclk_p_q;
  logic                     din_m_q, din_s_q;

  // Receiver and command state
  logic [7:0]               rx_sh_q, rx_sh_d;     // Incoming bits
  logic [2:0]               rx_cnt_q, rx_cnt_d;   // Bit index in byte
  acc_state_e               st_q, st_d;           // Command phase
  logic [4:0]               addr_q, addr_d;       // Register pointer
  logic [5:0]               left_q, left_d;       // Registers remaining
  logic [REG_COUNT-1:0][7:0] regs_q, regs_d;      // Register file

  // Readout state
  logic                     cont_q, cont_d;       // Continuous readout
  logic                     stby_q, stby_d;       // Standby flag
  logic                     pend_q, pend_d;       // Single read pending
  logic [6:0]               settle_q, settle_d;   // Periods to discard
  logic                     data_ready_n_n_q, data_ready_n_n_d;
  logic [31:0]              osh_q, osh_d;         // Output shifter
  logic [5:0]               ocnt_q, ocnt_d;       // Bits left to shift
  logic                     sdout_q, sdout_d;
  logic                     oe_q, oe_d;
  logic                     rst_pulse_q, rst_pulse_d;
  logic                     ofs_en_q, ofs_en_d;
  logic                     gan_en_q, gan_en_d;

  // Calibration state
  acc_cal_e                 cal_q, cal_d;
  logic                     cal_gain_q, cal_gain_d; // Gain, not offset
  logic [35:0]              acc_q, acc_d;           // Sum of readings
  logic [4:0]               nread_q, nread_d;
  logic [24:0]              rem_q, rem_d;           // Divider remainder
  logic [45:0]              quo_q, quo_d;           // Divider quotient
  logic [5:0]               dstep_q, dstep_d;
  logic [23:0]              dvsr_q, dvsr_d;

  // Combinational helpers
  logic                     sclk_rise, sclk_fall, byte_done;
  logic [7:0]               rx_byte;
  logic [7:0]               rd_byte;
  logic [35:0]              sum_n;
  logic [24:0]              rem_try;

  assign sclk_rise = sclk_s_q & ~sclk_p_q;
  assign sclk_fall = ~sclk_s_q & sclk_p_q;
  assign byte_done = sclk_rise & ~cs_s_q & (rx_cnt_q == 3'h7);
  assign rx_byte   = {rx_sh_q[6:0], din_s_q};
  assign rd_byte   = (addr_q < REG_NUM) ? regs_q[addr_q] : 8'h00;
  assign sum_n     = acc_q + {{4{conv.data[31]}}, conv.data};
  assign rem_try   = {rem_q[23:0], GAIN_NUM[dstep_q]};

  // Outputs straight from flops
  assign sdout        = sdout_q;
  assign sdout_oe     = oe_q;
  assign data_ready_n = data_ready_n_n_q;
  assign conv_restart = rst_pulse_q;
  assign standby      = stby_q;
  assign offset_en    = ofs_en_q;
  assign gain_en      = gan_en_q;
  assign offset_word  = {regs_q[7], regs_q[6], regs_q[5]};
  assign gain_word    = {regs_q[10], regs_q[9], regs_q[8]};

  // Next-state logic for the whole block
  always_comb begin
    rx_sh_d     = rx_sh_q;
    rx_cnt_d    = rx_cnt_q;
    st_d        = st_q;
    addr_d      = addr_q;
    left_d      = left_q;
    regs_d      = regs_q;
    cont_d      = cont_q;
    stby_d      = stby_q;
    pend_d      = pend_q;
    settle_d    = settle_q;
    data_ready_n_n_d    = data_ready_n_n_q;
    osh_d       = osh_q;
    ocnt_d      = ocnt_q;
    sdout_d     = sdout_q;
    oe_d        = ~cs_s_q;
    rst_pulse_d = 1'b0;
    cal_d       = cal_q;
    cal_gain_d  = cal_gain_q;
    acc_d       = acc_q;
    nread_d     = nread_q;
    rem_d       = rem_q;
    quo_d       = quo_q;
    dstep_d     = dstep_q;
    dvsr_d      = dvsr_q;
    // Correction off in sinc mode; gain off while any calibration averages, offset only while an offset calibration averages
    ofs_en_d = ~sinc_mode & ~((cal_q == CAL_ACC) & ~cal_gain_q);
    gan_en_d = ~sinc_mode & (cal_q != CAL_ACC);

    // Receive bits on rising edges, MSB first
    if (sclk_rise && !cs_s_q) begin
      rx_sh_d  = rx_byte;
      rx_cnt_d = rx_cnt_q + 3'h1;
    end

    // Shift data out on falling edges; ready returns high
    if (sclk_fall && !cs_s_q) begin
      data_ready_n_n_d = 1'b1;
      if (ocnt_q != 6'h00) begin
        sdout_d = osh_q[31];
        osh_d   = {osh_q[30:0], 1'b0};
        ocnt_d  = ocnt_q - 6'h01;
      end else if (st_q == ST_ROUT && left_q != 6'h00) begin
        sdout_d = rd_byte[7];
        osh_d   = {rd_byte[6:0], 25'h0000000};
        ocnt_d  = 6'h07;
        addr_d  = addr_q + 5'h01;
        left_d  = left_q - 6'h01;
      end else begin
        sdout_d = 1'b0;
      end
    end

    // Command decode at the eighth rising edge of each byte
    if (byte_done) begin
      unique case (st_q)
        ST_OP: begin
          if (rx_byte[7:1] == OP_WAKE_HI) begin
            stby_d = 1'b0;
          end else if (rx_byte[7:1] == OP_STBY_HI) begin
            stby_d = 1'b1;
          end else if (rx_byte[7:1] == OP_SYNC_HI) begin
            rst_pulse_d = 1'b1;
            settle_d    = SYNC_SETTLE;
            data_ready_n_n_d    = 1'b1;
            ocnt_d      = 6'h00;
          end else if (rx_byte[7:1] == OP_RESET_HI) begin
            regs_d      = REG_DEFAULTS;
            cont_d      = 1'b1;
            stby_d      = 1'b0;
            pend_d      = 1'b0;
            rst_pulse_d = 1'b1;
            settle_d    = SYNC_SETTLE;
            data_ready_n_n_d    = 1'b1;
            ocnt_d      = 6'h00;
            cal_d       = CAL_IDLE;
          end else if (rx_byte == OP_CONTINUOUS_READ_CMD) begin
            cont_d = 1'b1;
            // Continuous read after a calibrate opcode starts averaging
            if (cal_q == CAL_ARM) begin
              cal_d   = CAL_ACC;
              acc_d   = 36'h000000000;
              nread_d = 5'h00;
            end
          end else if (rx_byte == OP_STOP_CONTINUOUS_CMD) begin
            cont_d   = 1'b0;
            data_ready_n_n_d = 1'b1;
            ocnt_d   = 6'h00;
          end else if (rx_byte == OP_RDATA) begin
            pend_d = 1'b1;
          end else if (rx_byte[7:5] == OP_REGISTER_READ_CMD_HI) begin
            addr_d = rx_byte[4:0];
            st_d   = ST_RCNT;
          end else if (rx_byte[7:5] == OP_REGISTER_WRITE_CMD_HI) begin
            addr_d = rx_byte[4:0];
            st_d   = ST_WCNT;
          end else if (rx_byte == OP_OFFSET_CAL_CMD || rx_byte == OP_GAIN_CAL_CMD) begin
            // A second calibrate opcode is ignored while one is busy
            if (cal_q == CAL_IDLE) begin
              cal_d      = CAL_ARM;
              cal_gain_d = rx_byte[0];
            end
          end
          // Any other byte falls through with no effect
        end
        ST_RCNT: begin
          left_d = {1'b0, rx_byte[4:0]} + 6'h01;
          ocnt_d = 6'h00;
          st_d   = ST_ROUT;
        end
        ST_WCNT: begin
          left_d = {1'b0, rx_byte[4:0]} + 6'h01;
          st_d   = ST_WDATA;
        end
        ST_WDATA: begin
          // Identification nibble is read only; unmapped writes drop
          if (addr_q == ADDR_ID) begin
            regs_d[0] = {ID_NIBBLE, rx_byte[3:0]};
          end else if (addr_q < REG_NUM) begin
            regs_d[addr_q] = rx_byte;
          end
          addr_d      = addr_q + 5'h01;
          left_d      = left_q - 6'h01;
          rst_pulse_d = 1'b1;
          settle_d    = REGISTER_WRITE_CMD_SETTLE;
          data_ready_n_n_d    = 1'b1;
          if (left_q == 6'h01) begin
            st_d = ST_OP;
          end
        end
        ST_ROUT: begin
          // Bytes clocked during readout are not decoded
          if (left_q == 6'h00 && ocnt_q == 6'h00) begin
            st_d = ST_OP;
          end
        end
      endcase
    end

    // Each conversion result; standby halts conversions. A result that
    // lands in the restart cycle belongs to the aborted run, so it must
    // not eat into the fresh settle count
    if (conv.valid && !stby_q && !rst_pulse_d) begin
      if (cal_q == CAL_ACC) begin
        acc_d   = sum_n;
        nread_d = nread_q + 5'h01;
        if (nread_q == CAL_LAST) begin
          if (!cal_gain_q) begin
            regs_d[ADDR_OFC0]        = sum_n[19:12];
            regs_d[ADDR_OFC0 + 5'h1] = sum_n[27:20];
            regs_d[ADDR_OFC0 + 5'h2] = sum_n[35:28];
            cal_d = CAL_IDLE;
          end else begin
            cal_d   = CAL_DIV;
            dvsr_d  = sum_n[35:12];
            dstep_d = DIV_FIRST;
            rem_d   = 25'h0000000;
            quo_d   = 46'h000000000000;
          end
        end
      end else if (settle_q != 7'h00) begin
        settle_d = settle_q - 7'h01;
      end else if ((cont_q || pend_q) && cal_q == CAL_IDLE
                   && st_q != ST_ROUT) begin
        data_ready_n_n_d = 1'b0;
        sdout_d  = conv.data[31];
        osh_d    = {conv.data[30:0], 1'b0};
        ocnt_d   = 6'h1f;
        pend_d   = 1'b0;
      end
    end

    // Gain divider: one quotient bit per cycle
    if (cal_q == CAL_DIV) begin
      if (dvsr_q[23] || dvsr_q == 24'h000000) begin
        cal_d = CAL_IDLE;           // Unusable reading keeps old word
      end else begin
        if (rem_try >= {1'b0, dvsr_q}) begin
          rem_d = rem_try - {1'b0, dvsr_q};
          quo_d = {quo_q[44:0], 1'b1};
        end else begin
          rem_d = rem_try;
          quo_d = {quo_q[44:0], 1'b0};
        end
        dstep_d = dstep_q - 6'h01;
        if (dstep_q == 6'h00) begin
          // Saturate a factor that does not fit the 24-bit word
          if (|quo_d[45:24]) begin
            quo_d = 46'h000000ffffff;
          end
          regs_d[ADDR_FSC0]        = quo_d[7:0];
          regs_d[ADDR_FSC0 + 5'h1] = quo_d[15:8];
          regs_d[ADDR_FSC0 + 5'h2] = quo_d[23:16];
          cal_d = CAL_IDLE;
        end
      end
    end

    // Chip select high frames every command and cancels stop mode
    if (cs_s_q) begin
      rx_cnt_d = 3'h0;
      st_d     = ST_OP;
      cont_d   = 1'b1;
      stby_d   = 1'b0;
      // Output bit kept: a result loaded while deselected keeps its MSB
    end
  end

  // Synchronisers; the pins come from the host's domain
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_m_q   <= 1'b1;
      cs_s_q   <= 1'b1;
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_p_q <= 1'b0;
      din_m_q  <= 1'b0;
      din_s_q  <= 1'b0;
    end else begin
      cs_m_q   <= pins.cs_n;
      cs_s_q   <= cs_m_q;
      sclk_m_q <= pins.sclk;
      sclk_s_q <= sclk_m_q;
      sclk_p_q <= sclk_s_q;
      din_m_q  <= pins.din;
      din_s_q  <= din_m_q;
    end
  end

  // State registers; hardware reset matches the soft reset command
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_sh_q     <= 8'h00;
      rx_cnt_q    <= 3'h0;
      st_q        <= ST_OP;
      addr_q      <= 5'h00;
      left_q      <= 6'h00;
      regs_q      <= REG_DEFAULTS;
      cont_q      <= 1'b1;
      stby_q      <= 1'b0;
      pend_q      <= 1'b0;
      settle_q    <= SYNC_SETTLE;
      data_ready_n_n_q    <= 1'b1;
      osh_q       <= 32'h00000000;
      ocnt_q      <= 6'h00;
      sdout_q     <= 1'b0;
      oe_q        <= 1'b0;
      rst_pulse_q <= 1'b0;
      ofs_en_q    <= 1'b0;
      gan_en_q    <= 1'b0;
      cal_q       <= CAL_IDLE;
      cal_gain_q  <= 1'b0;
      acc_q       <= 36'h000000000;
      nread_q     <= 5'h00;
      rem_q       <= 25'h0000000;
      quo_q       <= 46'h000000000000;
      dstep_q     <= 6'h00;
      dvsr_q      <= 24'h000000;
    end else begin
      rx_sh_q     <= rx_sh_d;
      rx_cnt_q    <= rx_cnt_d;
      st_q        <= st_d;
      addr_q      <= addr_d;
      left_q      <= left_d;
      regs_q      <= regs_d;
      cont_q      <= cont_d;
      stby_q      <= stby_d;
      pend_q      <= pend_d;
      settle_q    <= settle_d;
      data_ready_n_n_q    <= data_ready_n_n_d;
      osh_q       <= osh_d;
      ocnt_q      <= ocnt_d;
      sdout_q     <= sdout_d;
      oe_q        <= oe_d;
      rst_pulse_q <= rst_pulse_d;
      ofs_en_q    <= ofs_en_d;
      gan_en_q    <= gan_en_d;
      cal_q       <= cal_d;
      cal_gain_q  <= cal_gain_d;
      acc_q       <= acc_d;
      nread_q     <= nread_d;
      rem_q       <= rem_d;
      quo_q       <= quo_d;
      dstep_q     <= dstep_d;
      dvsr_q      <= dvsr_d;
    end
  end

endmodule

/* File: hdl/acc_pkg.sv */
// Constants and carrier types for the serial command and calibration block
package acc_pkg;

  // Opcodes; control commands compare only the top seven bits
  localparam logic [6:0] OP_WAKE_HI   = 7'h00;
  localparam logic [6:0] OP_STBY_HI   = 7'h01;
  localparam logic [6:0] OP_SYNC_HI   = 7'h02;
  localparam logic [6:0] OP_RESET_HI  = 7'h03;
  localparam logic [7:0] OP_CONTINUOUS_READ_CMD    = 8'h10;
  localparam logic [7:0] OP_STOP_CONTINUOUS_CMD    = 8'h11;
  localparam logic [7:0] OP_RDATA     = 8'h12;
  localparam logic [2:0] OP_REGISTER_READ_CMD_HI   = 3'h1;
  localparam logic [2:0] OP_REGISTER_WRITE_CMD_HI   = 3'h2;
  localparam logic [7:0] OP_OFFSET_CAL_CMD    = 8'h60;
  localparam logic [7:0] OP_GAIN_CAL_CMD    = 8'h61;

  // Host spacing between bytes, in master clock cycles (host side duty)
  localparam int unsigned GAP_MCLK    = 24;

  // Data periods lost after restart events, and index of the last reading a calibration averages
  localparam logic [6:0] SYNC_SETTLE  = 7'h40;
  localparam logic [6:0] REGISTER_WRITE_CMD_SETTLE  = 7'h3f;
  localparam logic [4:0] CAL_LAST     = 5'h0f;

  // Register file
  localparam logic [4:0] REG_NUM      = 5'h0b;
  localparam int unsigned REG_COUNT   = 11;
  localparam logic [4:0] ADDR_ID      = 5'h00;
  localparam logic [4:0] ADDR_OFC0    = 5'h05;
  localparam logic [4:0] ADDR_FSC0    = 5'h08;
  // Identification nibble, value is arbitrary
  localparam logic [3:0] ID_NIBBLE    = 4'h0;
  localparam logic [8*REG_COUNT-1:0] REG_DEFAULTS = {
    8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h03, 8'h32, 8'h08, 8'h52, {ID_NIBBLE, 4'h0}};

  // Gain calibration divider
  localparam logic [23:0] FULL_SCALE  = 24'h7fffff;
  localparam logic [45:0] GAIN_NUM    = {FULL_SCALE, 22'h000000};
  localparam logic [5:0]  DIV_FIRST   = 6'h2d;

  // Serial pins as seen by the block
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } acc_pins_s;

  // One conversion result per data period
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } acc_conv_s;

  typedef enum logic [4:0] {
    ST_OP    = 5'b00001,
    ST_RCNT  = 5'b00010,
    ST_WCNT  = 5'b00100,
    ST_WDATA = 5'b01000,
    ST_ROUT  = 5'b10000
  } acc_state_e;

  typedef enum logic [3:0] {
    CAL_IDLE = 4'b0001,
    CAL_ARM  = 4'b0010,
    CAL_ACC  = 4'b0100,
    CAL_DIV  = 4'b1000
  } acc_cal_e;

endpackage
